//--- dv/sensor_link_assertions.sv
// concurrent checks on the link between the sensor end and the controller end
`timescale 1ns/1ps
module sensor_link_assertions (
	input  wire logic       CLK,
	input  wire logic       SYS_RST,
	input  wire logic       row_clk,
	input  wire logic       frame_start,
	input  wire logic       cfg_sclk,
	input  wire logic       cfg_sdata,
	input  wire logic       cfg_sen,
	input  wire logic [9:0] pix_data,
	input  wire logic       pix_valid,
	input  wire logic       ref_level,
	input  wire logic       line_end
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// ********************************
	// sequences
	// ********************************
	// 145-cycle blanking after a row is selected; buses checked quiet on its first 8 cycles and its last
	sequence s_blank;
		(ref_level && !pix_valid) [*8] ##137 (ref_level && !pix_valid);
	endsequence
	sequence s_word;
		cfg_sen [*8] ##24 cfg_sen;
	endsequence
	// ********************************
	// properties
	// ********************************
	property p_row_start; row_clk |-> ##1 s_blank ##1 pix_valid; endproperty
	a_row_start: assert property (p_row_start) else $error("blanking length wrong");
	property p_ref_active; !ref_level |-> pix_valid; endproperty
	a_ref_active: assert property (p_ref_active) else $error("reference released off pixels");
	property p_line_last; line_end |-> pix_valid ##1 !pix_valid; endproperty
	a_line_last: assert property (p_line_last) else $error("line end not on last pixel");
	property p_valid_run; pix_valid && !line_end |=> pix_valid; endproperty
	a_valid_run: assert property (p_valid_run) else $error("gap inside line");
	property p_quiet_bus; !pix_valid |-> pix_data == 10'h000; endproperty
	a_quiet_bus: assert property (p_quiet_bus) else $error("data outside active line");
	property p_frame_row; frame_start |=> row_clk; endproperty
	a_frame_row: assert property (p_frame_row) else $error("no row pulse after frame start");
	property p_row_hold; pix_valid |-> !row_clk; endproperty
	a_row_hold: assert property (p_row_hold) else $error("row pulse during line");
	property p_cfg_frame; $rose(cfg_sen) |-> s_word ##1 !cfg_sen; endproperty
	a_cfg_frame: assert property (p_cfg_frame) else $error("config frame length wrong");
	property p_sclk_frame; !cfg_sen |-> !cfg_sclk; endproperty
	a_sclk_frame: assert property (p_sclk_frame) else $error("serial clock outside frame");
	property p_sdata_hold; $rose(cfg_sclk) |-> $stable(cfg_sdata); endproperty
	a_sdata_hold: assert property (p_sdata_hold) else $error("data moved at shift edge");
endmodule

//--- dv/testbench.sv
// self-checking bench joining the sensor end and the controller end
`timescale 1ns/1ps
module testbench import sensor_readout_pkg::*;;
	typedef struct {logic [2:0] mode; logic [11:0] w, n, rs, cs; logic [9:0] ev, od;} row_t;
	logic CLK, SYS_RST, START, CFG_REQ, BUSY, FRAME_DONE, PIX_VALID;
	logic [9:0] ADC_EVEN, ADC_ODD, PIX_DATA;
	logic [11:0] LINE_WIDTH, LINE_COUNT, CFG_DATA, ROW_ADDR, COL_ADDR;
	logic [3:0] CFG_ADDR;
	color_chan_t COLOR_CHAN;
	int err_count, samples_checked, cycles, idx, lines_seen, pix_cnt, gap;
	logic [11:0] exp_row, exp_col;
	logic [10:0] fwd;
	row_t cur;
	// max width first, then interleave with odd width, nondestructive at last column start, top rows
	row_t rows [4] = '{
		'{3'h0, 12'h8A2, 12'h001, 12'h000, 12'h000, 10'h155, 10'h2AA},
		'{3'h1, 12'h007, 12'h003, 12'h007, 12'h001, 10'h0F0, 10'h30F},
		'{3'h2, 12'h004, 12'h002, 12'h001, 12'h05B, 10'h3FF, 10'h001},
		'{3'h3, 12'h001, 12'h002, 12'hBB8, 12'h000, 10'h001, 10'h3FE}};
	sensor_link_if link();
	image_sensor_row_readout u_image_sensor_row_readout (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(link),
		.ADC_EVEN(ADC_EVEN), .ADC_ODD(ADC_ODD), .COLOR_CHAN(COLOR_CHAN), .ROW_ADDR(ROW_ADDR), .COL_ADDR(COL_ADDR));
	camera_row_controller u_camera_row_controller (.CLK(CLK), .SYS_RST(SYS_RST), .LINK(link), .START(START),
		.LINE_WIDTH(LINE_WIDTH), .LINE_COUNT(LINE_COUNT), .CFG_REQ(CFG_REQ), .CFG_ADDR(CFG_ADDR),
		.CFG_DATA(CFG_DATA), .BUSY(BUSY), .FRAME_DONE(FRAME_DONE), .PIX_DATA(PIX_DATA), .PIX_VALID(PIX_VALID));
	sensor_link_assertions u_sensor_link_assertions (.CLK(CLK), .SYS_RST(SYS_RST), .row_clk(link.row_clk),
		.frame_start(link.frame_start), .cfg_sclk(link.cfg_sclk), .cfg_sdata(link.cfg_sdata),
		.cfg_sen(link.cfg_sen), .pix_data(link.pix_data), .pix_valid(link.pix_valid),
		.ref_level(link.ref_level), .line_end(link.line_end));
	// ********************************
	// tasks
	// ********************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("errors=%0d checks=%0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic cfg_write(input logic [3:0] a, input logic [11:0] d);
		int k;
		@(negedge CLK);
		CFG_REQ = 1'b1;
		CFG_ADDR = a;
		CFG_DATA = d;
		@(negedge CLK);
		CFG_REQ = 1'b0;
		k = 0;
		while (BUSY === 1'b1 && k < 40) begin
			@(negedge CLK);
			k++;
		end
		check(k, 32);
		repeat (2) @(negedge CLK);
	endtask
	// the controller is told the width separately, so both ends must agree
	task automatic run_frame(input int i);
		int k;
		cur = rows[i];
		ADC_EVEN = cur.ev;
		ADC_ODD = cur.od;
		lines_seen = 0;
		pix_cnt = 0;
		idx = 0;
		// spacing is only owed between rows of one frame, so the first row of a frame is let through
		gap = 4096;
		@(negedge CLK);
		START = 1'b1;
		LINE_WIDTH = cur.w;
		LINE_COUNT = cur.n;
		@(negedge CLK);
		START = 1'b0;
		k = 0;
		while (FRAME_DONE !== 1'b1 && k < cur.n * (cur.w + 200) + 100) begin
			@(negedge CLK);
			k++;
		end
		check(FRAME_DONE, 1'b1);
		check(lines_seen, cur.n);
		check(pix_cnt, cur.w * cur.n);
		repeat (3) @(negedge CLK);
	endtask
	// ********************************
	// clock, watchdog and link monitor
	// ********************************
	initial begin
		CLK = 1'b0;
		forever #25 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end
	always @(negedge CLK) if (SYS_RST === 1'b0) begin
		check({PIX_VALID, PIX_DATA}, fwd);
		fwd = {link.pix_valid, link.pix_data};
		if (link.row_clk === 1'b1) begin
			check(gap >= 147 + cur.w, 1);
			gap = 1;
		end else gap++;
		if (link.pix_valid === 1'b1) begin
			if (idx == 0) begin
				exp_row = (lines_seen == 0) ? cur.rs : exp_row + 12'h001;
				check(ROW_ADDR, exp_row);
			end
			exp_col = 12'(cur.cs * COL_STEP + idx);
			check(COL_ADDR, exp_col);
			check(link.pix_data, (cur.mode[0] && idx[0]) ? cur.od : cur.ev);
			check(COLOR_CHAN, {exp_row[0], exp_col[0]});
			idx++;
			pix_cnt++;
		end
		if (link.line_end === 1'b1) begin
			check(idx, cur.w);
			idx = 0;
			lines_seen++;
		end
	end
	// ********************************
	// main sequence
	// ********************************
	initial begin
		{SYS_RST, START, CFG_REQ, CFG_ADDR, CFG_DATA, LINE_WIDTH, LINE_COUNT} = {1'b1, 42'h0};
		{ADC_EVEN, ADC_ODD, err_count, samples_checked, cycles, gap} = 0;
		cur = rows[0];
		fwd = 11'h000;
		repeat (6) @(negedge CLK);
		check({link.ref_level, link.pix_valid, link.row_clk, link.cfg_sen, BUSY, FRAME_DONE}, 6'h20);
		SYS_RST = 1'b0;
		for (int i = 0; i < 4; i++) begin
			cfg_write(CFG_COL_START, rows[i].cs);
			cfg_write(CFG_ROW_START, rows[i].rs);
			cfg_write(CFG_MODE, {9'h000, rows[i].mode});
			cfg_write(CFG_WIDTH, rows[i].w);
			run_frame(i);
		end
		// out-of-range words must leave the last good settings in place
		cfg_write(CFG_WIDTH, 12'h000);
		cfg_write(CFG_ROW_START, 12'hBBA);
		run_frame(3);
		// a reset between frames must bring back the power-up settings, shown by a full default frame
		SYS_RST = 1'b1;
		repeat (2) @(negedge CLK);
		check({link.ref_level, link.pix_valid, link.row_clk, link.cfg_sen, BUSY, FRAME_DONE}, 6'h20);
		check({COLOR_CHAN, ROW_ADDR, COL_ADDR}, 26'h0000000);
		SYS_RST = 1'b0;
		run_frame(0);
		final_report();
	end
endmodule

//--- hdl/camera_row_controller.sv
// controller end: serial configuration writer and frame/row pulse timing
`timescale 1ns/1ps
module camera_row_controller import sensor_readout_pkg::*; (
	input  wire logic                  CLK,
	input  wire logic                  SYS_RST,
	sensor_link_if.controller          LINK,
	input  wire logic                  START,
	input  wire logic [CNT_W-1:0]      LINE_WIDTH,
	input  wire logic [CNT_W-1:0]      LINE_COUNT,
	input  wire logic                  CFG_REQ,
	input  wire logic [CFG_ADDR_W-1:0] CFG_ADDR,
	input  wire logic [CFG_DATA_W-1:0] CFG_DATA,
	output logic                       BUSY,
	output logic                       FRAME_DONE,
	output logic [PIX_W-1:0]           PIX_DATA,
	output logic                       PIX_VALID
);
	// ********************************
	// state and registers
	// ********************************
	typedef enum logic [3:0] {
		C_IDLE = 4'b0001,
		C_CFG  = 4'b0010,
		C_ROW  = 4'b0100,
		C_WAIT = 4'b1000
	} ctl_state_t;

	ctl_state_t          state_r;
	logic [CFG_BITS-1:0] shift_r;
	logic [4:0]          bit_cnt_r;
	logic                phase_r;
	logic [11:0]         width_r;
	logic [11:0]         lines_left_r;
	logic [12:0]         wait_cnt_r;

	wire        last_bit   = phase_r & (bit_cnt_r == 5'(CFG_BITS - 1));
	wire [12:0] line_cycles = 13'({1'b0, ROW_BLANK_CYC} + 13'({1'b0, width_r} * {1'b0, PIXEL_CYC}) + {1'b0, LINE_MARGIN});
	wire        go_frame   = START & (LINE_COUNT != 12'h000) & (LINE_WIDTH != 12'h000);

	// ********************************
	// sequencing
	// ********************************
	// configuration wins over a frame start requested in the same cycle
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_r          <= C_IDLE;
			shift_r          <= '0;
			bit_cnt_r        <= 5'h00;
			phase_r          <= 1'b0;
			width_r          <= 12'h000;
			lines_left_r     <= 12'h000;
			wait_cnt_r       <= 13'h0000;
			LINK.row_clk     <= 1'b0;
			LINK.frame_start <= 1'b0;
			LINK.cfg_sclk    <= 1'b0;
			LINK.cfg_sdata   <= 1'b0;
			LINK.cfg_sen     <= 1'b0;
			BUSY             <= 1'b0;
			FRAME_DONE       <= 1'b0;
		end else begin
			LINK.row_clk     <= 1'b0;
			LINK.frame_start <= 1'b0;
			FRAME_DONE       <= 1'b0;
			case (state_r)
				C_IDLE: begin
					if (CFG_REQ) begin
						shift_r        <= {CFG_ADDR, CFG_DATA};  // see [RULE6]
						bit_cnt_r      <= 5'h00;
						phase_r        <= 1'b0;
						LINK.cfg_sen   <= 1'b1;
						LINK.cfg_sdata <= CFG_ADDR[CFG_ADDR_W-1];
						BUSY           <= 1'b1;
						state_r        <= C_CFG;
					end else if (go_frame) begin
						width_r          <= LINE_WIDTH;
						lines_left_r     <= LINE_COUNT;
						LINK.frame_start <= 1'b1;  // see [RULE11]
						BUSY             <= 1'b1;
						state_r          <= C_ROW;
					end
				end
				C_CFG: begin
					phase_r       <= ~phase_r;
					LINK.cfg_sclk <= ~phase_r;  // see [RULE7]
					if (phase_r) begin
						shift_r        <= {shift_r[CFG_BITS-2:0], 1'b0};
						bit_cnt_r      <= bit_cnt_r + 5'h01;
						LINK.cfg_sdata <= shift_r[CFG_BITS-2];
					end
					if (last_bit) begin
						LINK.cfg_sen <= 1'b0;
						BUSY         <= 1'b0;
						state_r      <= C_IDLE;
					end
				end
				C_ROW: begin
					LINK.row_clk <= 1'b1;  // see [RULE1]
					lines_left_r <= lines_left_r - 12'h001;
					wait_cnt_r   <= line_cycles;
					state_r      <= C_WAIT;
				end
				C_WAIT: begin
					if (wait_cnt_r != 13'h0000) begin
						wait_cnt_r <= wait_cnt_r - 13'h0001;  // see [RULE12]
					end else if (lines_left_r != 12'h000) begin
						state_r <= C_ROW;  // see [RULE4]
					end else begin
						FRAME_DONE <= 1'b1;
						BUSY       <= 1'b0;
						state_r    <= C_IDLE;
					end
				end
				default: begin
					state_r <= C_IDLE;
				end
			endcase
		end
	end

	// ********************************
	// pixel capture
	// ********************************
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PIX_DATA  <= '0;
			PIX_VALID <= 1'b0;
		end else begin
			PIX_DATA  <= LINK.pix_data;
			PIX_VALID <= LINK.pix_valid;
		end
	end
endmodule

//--- hdl/image_sensor_row_readout.sv
// sensor end: row sequencer, configuration shifter, converter interleave and colour tagging
// Contract
// [RULE1] row clock pulse starts each line, selects row
// [RULE2] column calibration blanking after selection, before pixels
// [RULE3] one pixel per pixel period during active line; the code gives one per 50 ns clock, the 25 ns period being rounded up
// [RULE4] frame time is lines times blanking-plus-pixels
// [RULE5] two converters interleaved onto one ten-bit output
// [RULE6] multiplexer setting loaded through configuration bus
// [RULE7] shift register start positions loaded serially
// [RULE8] reference on buses in blanking, always in nondestructive
// [RULE9] bayer origin green on red row, two greens
// [RULE10] sequencer makes array timing, controller gives rows
// [RULE11] frame start loads row, row clock loads column
// [RULE12] controller waits whole line before next row
`timescale 1ns/1ps
module image_sensor_row_readout import sensor_readout_pkg::*; (
	input  wire logic               CLK,
	input  wire logic               SYS_RST,
	sensor_link_if.sensor           LINK,
	input  wire logic [PIX_W-1:0]   ADC_EVEN,
	input  wire logic [PIX_W-1:0]   ADC_ODD,
	output color_chan_t             COLOR_CHAN,
	output logic [CNT_W-1:0]        ROW_ADDR,
	output logic [CNT_W-1:0]        COL_ADDR
);
	// ********************************
	// state and registers
	// ********************************
	typedef enum logic [2:0] {
		S_IDLE   = 3'b001,
		S_BLANK  = 3'b010,
		S_ACTIVE = 3'b100
	} seq_state_t;

	seq_state_t          state_r;
	logic [11:0]         blank_cnt_r;
	logic [11:0]         pix_cnt_r;
	logic [11:0]         period_cnt_r;
	logic [11:0]         col_start_r;
	logic [11:0]         row_start_r;
	logic [2:0]          mode_r;
	logic [11:0]         width_r;
	logic [11:0]         row_next_r;
	logic [11:0]         row_sel_r;
	logic [15:0]         col_base_r;
	logic [PIX_W-1:0]    odd_hold_r;
	logic [CFG_BITS-1:0] cfg_shift_r;
	logic [4:0]          cfg_cnt_r;
	logic                sclk_q_r;
	logic                sen_q_r;

	// ********************************
	// decoding
	// ********************************
	function automatic color_chan_t bayer_chan(input logic row_odd, input logic col_odd);
		bayer_chan = color_chan_t'({row_odd, col_odd});
	endfunction

	function automatic logic [15:0] times_step(input logic [11:0] idx);
		times_step = 16'({4'h0, idx} * COL_STEP);
	endfunction

	// shift clock edges come from last cycle's level; both ends run on one clock,
	// so no synchroniser is needed and the edge costs one cycle of latency
	wire               sclk_rise   = LINK.cfg_sclk & ~sclk_q_r;
	wire               word_done   = sen_q_r & ~LINK.cfg_sen & (cfg_cnt_r == 5'(CFG_BITS));
	wire [3:0]         cfg_addr    = cfg_shift_r[CFG_BITS-1:CFG_ADDR_LSB];
	wire [11:0]        cfg_data    = cfg_shift_r[CFG_DATA_W-1:0];
	wire               row_start   = LINK.row_clk & (state_r == S_IDLE);
	// the pixel period rounds up to one clock here, so a pixel flows on every cycle of a line
	wire               pix_tick    = (period_cnt_r == PIXEL_CYC - 12'h001);
	wire               last_pix    = pix_tick & (pix_cnt_r == width_r - 12'h001);
	// absolute column, so colour and address follow a moved window
	wire [15:0]        col_abs     = col_base_r + {4'h0, pix_cnt_r};
	wire               interleave  = mode_r[MODE_INTERLEAVE];
	wire               nondestructive_readout = mode_r[MODE_NONDESTRUCTIVE];
	wire [PIX_W-1:0]   pix_sel     = (interleave & pix_cnt_r[0]) ? odd_hold_r : ADC_EVEN;
	// start and width words are checked here so a bad word cannot leave the array
	wire               width_ok    = (cfg_data != 12'h000) & (cfg_data <= MAX_PIXELS);
	wire               row_ok      = (cfg_data < MAX_LINES);
	wire               col_ok      = (times_step(cfg_data) < {4'h0, MAX_PIXELS});

	// ********************************
	// serial configuration
	// ********************************
	// the sensor never answers a word, so a lost word shows only as an unchanged setting
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			sclk_q_r    <= 1'b0;
			sen_q_r     <= 1'b0;
			cfg_shift_r <= '0;
			cfg_cnt_r   <= 5'h00;
		end else begin
			sclk_q_r <= LINK.cfg_sclk;
			sen_q_r  <= LINK.cfg_sen;
			if (!LINK.cfg_sen) begin
				cfg_cnt_r <= 5'h00;
			end else if (sclk_rise && cfg_cnt_r != 5'(CFG_BITS)) begin
				cfg_shift_r <= {cfg_shift_r[CFG_BITS-2:0], LINK.cfg_sdata};  // see [RULE7]
				cfg_cnt_r   <= cfg_cnt_r + 5'h01;
			end
		end
	end

	// a short word is dropped whole, a long word keeps its first 16 bits, out-of-range starts are refused
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			col_start_r <= COL_START_RST;
			row_start_r <= ROW_START_RST;
			mode_r      <= MODE_RST;
			width_r     <= MAX_PIXELS;
		end else if (word_done) begin
			if (cfg_addr == CFG_COL_START && col_ok) begin
				col_start_r <= cfg_data;  // see [RULE7]
			end else if (cfg_addr == CFG_ROW_START && row_ok) begin
				row_start_r <= cfg_data;  // see [RULE7]
			end else if (cfg_addr == CFG_MODE) begin
				mode_r <= cfg_data[2:0];  // see [RULE6]
			end else if (cfg_addr == CFG_WIDTH && width_ok) begin
				width_r <= cfg_data;
			end
		end
	end

	// ********************************
	// row sequencer
	// ********************************
	// row clocks arriving during blanking or active pixels are ignored
	// the row counter steps by one per accepted row; running past the array is the controller's concern
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			state_r      <= S_IDLE;
			blank_cnt_r  <= 12'h000;
			pix_cnt_r    <= 12'h000;
			period_cnt_r <= 12'h000;
			row_next_r   <= ROW_START_RST;
			row_sel_r    <= ROW_START_RST;
			col_base_r   <= 16'h0000;
		end else begin
			if (LINK.frame_start) begin
				row_next_r <= row_start_r;  // see [RULE11]
			end
			case (state_r)
				S_IDLE: begin
					if (row_start) begin
						row_sel_r   <= LINK.frame_start ? row_start_r : row_next_r;  // see [RULE1]
						row_next_r  <= (LINK.frame_start ? row_start_r : row_next_r) + 12'h001;
						col_base_r  <= times_step(col_start_r);  // see [RULE11]
						blank_cnt_r <= ROW_BLANK_CYC - 12'h001;
						state_r     <= S_BLANK;  // see [RULE10]
					end
				end
				S_BLANK: begin
					if (blank_cnt_r == 12'h000) begin
						pix_cnt_r    <= 12'h000;
						period_cnt_r <= 12'h000;
						state_r      <= S_ACTIVE;  // see [RULE2]
					end else begin
						blank_cnt_r <= blank_cnt_r - 12'h001;
					end
				end
				S_ACTIVE: begin
					// a slower pixel rate only needs a new period constant, the counter is kept
					period_cnt_r <= pix_tick ? 12'h000 : period_cnt_r + 12'h001;  // see [RULE3]
					if (last_pix) begin
						state_r <= S_IDLE;  // see [RULE4]
					end else if (pix_tick) begin
						pix_cnt_r <= pix_cnt_r + 12'h001;
					end
				end
				default: begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// ********************************
	// output stream
	// ********************************
	// the odd converter sample is held so both converters run at half the pixel rate
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			odd_hold_r     <= '0;
			LINK.pix_data  <= '0;
			LINK.pix_valid <= 1'b0;
			LINK.ref_level <= 1'b1;
			LINK.line_end  <= 1'b0;
			COLOR_CHAN     <= CH_GREEN_ON_RED_ROWS;
			ROW_ADDR       <= '0;
			COL_ADDR       <= '0;
		end else begin
			if (state_r == S_ACTIVE && pix_tick && !pix_cnt_r[0]) begin
				odd_hold_r <= ADC_ODD;  // see [RULE5]
			end
			LINK.pix_valid <= (state_r == S_ACTIVE) & pix_tick;  // see [RULE3]
			LINK.pix_data  <= (state_r == S_ACTIVE) ? pix_sel : '0;  // see [RULE5]
			LINK.ref_level <= nondestructive_readout | (state_r != S_ACTIVE);  // see [RULE8]
			LINK.line_end  <= (state_r == S_ACTIVE) & last_pix;
			// colour tag rides with the pixel it belongs to, one register stage like the data
			COLOR_CHAN     <= bayer_chan(row_sel_r[0], col_abs[0]);  // see [RULE9]
			ROW_ADDR       <= row_sel_r;
			COL_ADDR       <= col_abs[CNT_W-1:0];
		end
	end
endmodule

//--- hdl/sensor_link_if.sv
// link between the sensor readout and its camera controller
`timescale 1ns/1ps
interface sensor_link_if;
	logic       row_clk;
	logic       frame_start;
	logic       cfg_sclk;
	logic       cfg_sdata;
	logic       cfg_sen;
	logic [9:0] pix_data;
	logic       pix_valid;
	logic       ref_level;
	logic       line_end;

	modport sensor (
		input  row_clk,
		input  frame_start,
		input  cfg_sclk,
		input  cfg_sdata,
		input  cfg_sen,
		output pix_data,
		output pix_valid,
		output ref_level,
		output line_end
	);
	modport controller (
		output row_clk,
		output frame_start,
		output cfg_sclk,
		output cfg_sdata,
		output cfg_sen,
		input  pix_data,
		input  pix_valid,
		input  ref_level,
		input  line_end
	);
endinterface

//--- hdl/sensor_readout_pkg.sv
// shared constants and types for the row readout sensor and its controller
package sensor_readout_pkg;
	// ********************************
	// clock and timing
	// ********************************
	localparam int CLK_PERIOD_NS   = 50;
	localparam int ROW_BLANK_NS_X10 = 72000;
	localparam int PIXEL_PERIOD_PS  = 25000;
	localparam int ROW_BLANK_CYC_I  = (ROW_BLANK_NS_X10 + CLK_PERIOD_NS * 10 - 1) / (CLK_PERIOD_NS * 10);
	localparam int PIXEL_CYC_I     = (PIXEL_PERIOD_PS / (CLK_PERIOD_NS * 1000)) < 1 ? 1 :
	                                 (PIXEL_PERIOD_PS / (CLK_PERIOD_NS * 1000));
	localparam logic [11:0] ROW_BLANK_CYC = 12'(ROW_BLANK_CYC_I);
	localparam logic [11:0] PIXEL_CYC   = 12'(PIXEL_CYC_I);
	localparam logic [11:0] LINE_MARGIN = 12'h002;

	// ********************************
	// geometry
	// ********************************
	localparam int          PIX_W         = 10;
	localparam int          CNT_W         = 12;
	localparam logic [11:0] MAX_PIXELS    = 12'h8A2;
	localparam logic [11:0] MAX_LINES     = 12'hBBA;
	localparam logic [15:0] COL_STEP      = 16'h0018;

	// ********************************
	// configuration word: address in the top nibble, data below
	// ********************************
	localparam int         CFG_BITS      = 16;
	localparam int         CFG_ADDR_W    = 4;
	localparam int         CFG_DATA_W    = 12;
	localparam int         CFG_ADDR_LSB  = 12;
	localparam logic [3:0] CFG_COL_START = 4'h0;
	localparam logic [3:0] CFG_ROW_START = 4'h1;
	localparam logic [3:0] CFG_MODE      = 4'h2;
	localparam logic [3:0] CFG_WIDTH     = 4'h3;
	localparam int         MODE_INTERLEAVE = 0;
	localparam int         MODE_NONDESTRUCTIVE = 1;
	localparam logic [2:0]  MODE_RST       = 3'h0;
	localparam logic [11:0] COL_START_RST  = 12'h000;
	localparam logic [11:0] ROW_START_RST  = 12'h000;

	// ********************************
	// colour channels
	// ********************************
	typedef enum logic [1:0] {
		CH_GREEN_ON_RED_ROWS  = 2'h0,
		CH_RED                = 2'h1,
		CH_BLUE               = 2'h2,
		CH_GREEN_ON_BLUE_ROWS = 2'h3
	} color_chan_t;
endpackage
